// ===== logic/fmac_pkg.sv
// Purpose: constants for the fan monitor alert and configuration registers
// Assumes: 100 MHz system clock, 8-bit register port
// Notes: offsets are the device's register addresses
package fmac_pkg;
  // ***********************************************************************
  // register offsets
  // ***********************************************************************
  localparam logic [7:0] OFS_MASK_ONE = 8'h74;
  localparam logic [7:0] OFS_MASK_TWO = 8'h75;
  localparam logic [7:0] OFS_SUPPLY_LOW = 8'h76;
  localparam logic [7:0] OFS_TEMP_LOW = 8'h77;
  localparam logic [7:0] OFS_CONFIG_THREE = 8'h78;
  localparam logic [7:0] OFS_TIMER_STATUS = 8'h79;
  // ***********************************************************************
  // reset values
  // ***********************************************************************
  localparam logic [7:0] RST_MASK_ONE = 8'h00;
  localparam logic [7:0] RST_MASK_TWO = 8'h00;
  localparam logic [7:0] RST_CONFIG_THREE = 8'h00;
  localparam logic [7:0] RST_TIMER_STATUS = 8'h00;
  // ***********************************************************************
  // field positions
  // ***********************************************************************
  localparam int M1_SUPPLY_ONE = 1;
  localparam int M1_SUPPLY_TWO = 2;
  localparam int M1_REMOTE_ONE = 4;
  localparam int M1_LOCAL = 5;
  localparam int M1_REMOTE_TWO = 6;
  localparam int M1_STATUS_TWO = 7;
  localparam int M2_OVERTEMP = 1;
  localparam int M2_FAN_ONE = 2;
  localparam int M2_FAN_FOUR = 5;
  localparam int M2_DIODE_ONE = 6;
  localparam int M2_DIODE_TWO = 7;
  localparam int C3_ALERT = 0;
  localparam int C3_OVERHEAT_PIN_EN = 1;
  localparam int C3_BOOST = 2;
  localparam int C3_FAST = 3;
  localparam int C3_DC_LO = 4;
  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real TIMER_STEP_MS = 22.76;
  localparam int STEP_CYCLES = int'(TIMER_STEP_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam real FAST_TACH_MS = 250.0;
  localparam real SLOW_TACH_MS = 1000.0;
  localparam int FAST_TACH_CYCLES =
    int'(FAST_TACH_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int SLOW_TACH_CYCLES =
    int'(SLOW_TACH_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam logic [7:0] TIMER_MAX = 8'hFF;
endpackage

// ===== logic/fmac_tick.sv
// Purpose: periodic one-cycle tick from a programmable cycle count
// Assumes: period at least 1, counts on every rising clk_sys edge
// Notes: restarts when clear is high
`timescale 1ns/10ps
module fmac_tick #(
  parameter int W = 27
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  input wire logic [W-1:0] period,
  output logic tick
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire at_end = (cnt_r >= period - W'(1));

  // count up and wrap at the period
  assign cnt_nxt = (clear || at_end) ? '0 : cnt_r + W'(1);
  assign tick = at_end && !clear;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ===== logic/fmac_regs.sv
// Purpose: alert masks, extended bits, config 3 and overheat timer
// Assumes: register port is single-cycle, inputs synchronous to clk_sys
// Notes: overheat_pin_n is active low; alert_n output is active low
`timescale 1ns/10ps
module fmac_regs #(
  parameter int STEP_CYC = fmac_pkg::STEP_CYCLES,
  parameter int SLOW_CYC = fmac_pkg::SLOW_TACH_CYCLES,
  parameter int FAST_CYC = fmac_pkg::FAST_TACH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic lock,
  input wire logic [1:0] shared_pin_function,
  input wire logic overheat_pin_dir_out,
  input wire logic [7:0] timer_limit,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  input wire logic [9:0] supply_one_meas,
  input wire logic [9:0] supply_two_meas,
  input wire logic [9:0] remote_one_meas,
  input wire logic [9:0] local_meas,
  input wire logic [9:0] remote_two_meas,
  input wire logic high_byte_rd,
  input wire logic overheat_pin_n,
  output logic [7:0] supply_one_high,
  output logic [7:0] supply_two_high,
  output logic [7:0] remote_one_high,
  output logic [7:0] local_high,
  output logic [7:0] remote_two_high,
  output logic timer_event,
  output logic fan_two_is_alert,
  output logic alert_n,
  output logic overheat_enable,
  output logic fans_full,
  output logic tach_tick,
  output logic [3:0] continuous_tach,
  output logic [3:0] stretch_enable
);
  // ***********************************************************************
  // registers
  // ***********************************************************************
  logic [7:0] mask_one_r;
  logic [7:0] mask_two_r;
  logic [7:0] config_three_r;
  logic [7:0] assert_duration_count_r;
  logic assert_flag_lsb_r;
  logic frozen_r;
  logic [49:0] snap_r;
  logic [31:0] step_cnt_r;
  logic timer_event_r;
  logic overheat_pin_prev_r;

  // ***********************************************************************
  // decode
  // ***********************************************************************
  wire wr_m1 = reg_wr && reg_addr == fmac_pkg::OFS_MASK_ONE;
  wire wr_m2 = reg_wr && reg_addr == fmac_pkg::OFS_MASK_TWO;
  wire wr_c3 = reg_wr && reg_addr == fmac_pkg::OFS_CONFIG_THREE;
  wire rd_low = reg_rd && (reg_addr == fmac_pkg::OFS_SUPPLY_LOW ||
    reg_addr == fmac_pkg::OFS_TEMP_LOW);
  wire rd_tmr = reg_rd && reg_addr == fmac_pkg::OFS_TIMER_STATUS;
  wire [49:0] live = {supply_one_meas, supply_two_meas, remote_one_meas,
    local_meas, remote_two_meas};
  wire [49:0] shown = frozen_r ? snap_r : live;

  // pin function: enable bit plus pin-function field selects overheat input
  assign overheat_enable = config_three_r[fmac_pkg::C3_OVERHEAT_PIN_EN] &&
    shared_pin_function != 2'b00;
  wire overheat_pin_in = overheat_enable && !overheat_pin_dir_out && !overheat_pin_n;
  wire overheat_pin_rise = overheat_pin_in && !overheat_pin_prev_r;
  wire at_step = step_cnt_r >= 32'(STEP_CYC - 1);
  // timer flagged when count passes limit, limit zero flags at once
  wire over_limit = overheat_pin_in && (timer_limit == 8'h00 ||
    assert_duration_count_r > timer_limit);

  // ***********************************************************************
  // readback
  // ***********************************************************************
  wire [7:0] supply_lo = {2'b00, shown[31:30], shown[41:40], 2'b00};
  wire [7:0] temp_lo = {shown[1:0], shown[11:10], shown[21:20],
    2'b00};
  wire [7:0] tmr_rd = {assert_duration_count_r[7:1], assert_flag_lsb_r};
  assign reg_rdata =
    reg_addr == fmac_pkg::OFS_MASK_ONE ? mask_one_r :
    reg_addr == fmac_pkg::OFS_MASK_TWO ? mask_two_r :
    reg_addr == fmac_pkg::OFS_SUPPLY_LOW ? supply_lo :
    reg_addr == fmac_pkg::OFS_TEMP_LOW ? temp_lo :
    reg_addr == fmac_pkg::OFS_CONFIG_THREE ? config_three_r :
    reg_addr == fmac_pkg::OFS_TIMER_STATUS ? tmr_rd : 8'h00;
  assign supply_one_high = shown[49:42];
  assign supply_two_high = shown[39:32];
  assign remote_one_high = shown[29:22];
  assign local_high = shown[19:12];
  assign remote_two_high = shown[9:2];

  // ***********************************************************************
  // alert gating
  // ***********************************************************************
  wire [7:0] unmask_one = status_one & ~{1'b0, mask_one_r[6:0]};
  wire [7:0] st2 = {status_two[7:6], status_two[5] | timer_event_r,
    status_two[4:0]};
  wire [7:0] unmask_two = st2 & ~mask_two_r;
  wire any_alert = (|(unmask_one & 8'h76)) ||
    (!mask_one_r[fmac_pkg::M1_STATUS_TWO] && |(unmask_two & 8'hFE));
  assign fan_two_is_alert = config_three_r[fmac_pkg::C3_ALERT];
  assign alert_n = !(fan_two_is_alert && any_alert);
  assign timer_event = timer_event_r;

  // fan and tach controls
  assign fans_full = overheat_pin_in && config_three_r[fmac_pkg::C3_BOOST];
  assign continuous_tach = config_three_r[7:4];
  assign stretch_enable = ~config_three_r[7:4];
  fmac_tick #(.W(32)) u_tach (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(wr_c3 && !lock),
    .period(config_three_r[fmac_pkg::C3_FAST] ? 32'(FAST_CYC) :
      32'(SLOW_CYC)),
    .tick(tach_tick)
  );

  // ***********************************************************************
  // writable registers, lock guards config three
  // ***********************************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mask_one_r <= fmac_pkg::RST_MASK_ONE;
      mask_two_r <= fmac_pkg::RST_MASK_TWO;
      config_three_r <= fmac_pkg::RST_CONFIG_THREE;
    end else begin
      if (wr_m1) begin
        mask_one_r <= reg_wdata;
      end
      if (wr_m2) begin
        mask_two_r <= {reg_wdata[7:2], mask_two_r[1:0]}; // overtemp read only
      end
      if (wr_c3 && !lock) begin
        config_three_r <= reg_wdata;
      end
    end
  end

  // freeze snapshot on low-bit read until a high byte read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      frozen_r <= 1'b0;
      snap_r <= '0;
    end else if (rd_low) begin
      frozen_r <= 1'b1;
      if (!frozen_r) begin
        snap_r <= live;
      end
    end else if (high_byte_rd) begin
      frozen_r <= 1'b0;
    end
  end

  // overheat assertion timer; flag set beats read clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      assert_duration_count_r <= fmac_pkg::RST_TIMER_STATUS;
      assert_flag_lsb_r <= 1'b0;
      step_cnt_r <= '0;
      overheat_pin_prev_r <= 1'b0;
      timer_event_r <= 1'b0;
    end else begin
      overheat_pin_prev_r <= overheat_pin_in;
      if (!overheat_pin_in) begin
        step_cnt_r <= '0;
      end else if (at_step) begin
        step_cnt_r <= '0;
      end else begin
        step_cnt_r <= step_cnt_r + 32'd1;
      end
      if (overheat_pin_rise) begin
        assert_duration_count_r <= 8'h00;
      end else if (overheat_pin_in && at_step &&
          assert_duration_count_r != fmac_pkg::TIMER_MAX) begin
        assert_duration_count_r <= assert_duration_count_r + 8'd1;
      end
      if (overheat_pin_rise || (overheat_pin_in && |assert_duration_count_r[7:1])) begin
        assert_flag_lsb_r <= overheat_pin_rise ? 1'b1 :
          assert_duration_count_r[0];
      end else if (rd_tmr) begin
        assert_flag_lsb_r <= 1'b0;
      end
      if (over_limit) begin
        timer_event_r <= 1'b1;
      end else if (high_byte_rd) begin
        timer_event_r <= 1'b0;
      end
    end
  end

  // ***********************************************************************
  // checks
  // ***********************************************************************
  // alert path open: alert pin selected and status two not blocked
  sequence s_open_path;
    fan_two_is_alert && !mask_one_r[fmac_pkg::M1_STATUS_TWO];
  endsequence
  // first edge of a qualified overheat assertion
  sequence s_rise;
    overheat_pin_rise;
  endsequence
  // a timer status read while the overheat input is idle
  sequence s_idle_read;
    rd_tmr && !overheat_pin_in;
  endsequence
  // alert pin function and mask gating
  chk_alert_masked: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !fan_two_is_alert |-> alert_n)
    else $error("alert while disabled");
  chk_ool_block: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (mask_one_r[7] && (status_one & 8'h76 & ~mask_one_r) == 8'h00) |->
    alert_n) else $error("status two leaked");
  chk_alert_level: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (fan_two_is_alert && (status_one[5] && !mask_one_r[5])) |-> !alert_n)
    else $error("alert not raised");
  chk_fan_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_open_path ##0 (status_two[2] && !mask_two_r[2])) |-> !alert_n)
    else $error("fan fault not raised");
  chk_timer_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_open_path ##0 (timer_event_r && !mask_two_r[5])) |-> !alert_n)
    else $error("timer event not raised");
  chk_diode_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (s_open_path ##0 (status_two[6] && !mask_two_r[6])) |-> !alert_n)
    else $error("diode fault not raised");
  chk_alert_idle: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (status_one == 8'h00 && status_two == 8'h00 && !timer_event_r) |->
    alert_n) else $error("alert with nothing pending");
  // low-bit registers show live results while not frozen
  chk_supply_bits: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_addr == fmac_pkg::OFS_SUPPLY_LOW && !frozen_r) |-> reg_rdata ==
    {2'b00, supply_two_meas[1:0], supply_one_meas[1:0], 2'b00})
    else $error("supply low bits misplaced");
  chk_temp_bits: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_addr == fmac_pkg::OFS_TEMP_LOW && !frozen_r) |-> reg_rdata ==
    {remote_two_meas[1:0], local_meas[1:0], remote_one_meas[1:0], 2'b00})
    else $error("temperature low bits misplaced");
  // freeze window
  chk_freeze_set: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rd_low |=> frozen_r) else $error("low-bit read did not freeze");
  chk_freeze_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (frozen_r && !high_byte_rd) |=> $stable(snap_r))
    else $error("snapshot moved");
  // config three writes, lock and boost
  chk_config_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (wr_c3 && !lock) |=> config_three_r == $past(reg_wdata))
    else $error("unlocked write lost");
  chk_lock_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (wr_c3 && lock) |=> $stable(config_three_r))
    else $error("locked write took");
  chk_boost_fans: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    fans_full |-> (overheat_pin_in && config_three_r[2]))
    else $error("boost wrong");
  chk_boost_dir: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    overheat_pin_dir_out |-> !fans_full) else $error("boost on output pin");
  // overheat timer, flag and limit
  chk_flag_rise: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_rise |=> assert_flag_lsb_r) else $error("flag not set");
  chk_count_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_rise |=> (assert_duration_count_r == 8'h00) [*2])
    else $error("count early");
  chk_count_step: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (overheat_pin_in && !overheat_pin_rise && at_step &&
    assert_duration_count_r != fmac_pkg::TIMER_MAX) |=>
    assert_duration_count_r == $past(assert_duration_count_r) + 8'd1)
    else $error("count missed a step");
  chk_flag_clear: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_idle_read |=> !assert_flag_lsb_r) else $error("flag not cleared");
  chk_limit_over: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (overheat_pin_in && assert_duration_count_r > timer_limit) |=> timer_event_r)
    else $error("limit passed without event");
  chk_limit_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (overheat_pin_in && timer_limit == 8'h00) |=> timer_event_r)
    else $error("no immediate event");
endmodule

// ===== verification/fmac_host_model.sv
// Purpose: host side model that fetches high bytes after a low-bit read
// Assumes: fetch is a one-cycle request in the clk_sys domain
// Notes: gap sets how slowly the host comes back for the high bytes
`timescale 1ns/10ps
module fmac_host_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fetch,
  input wire logic [3:0] gap,
  output logic high_byte_rd
);
  logic [4:0] wait_r;
  // ***********************************************************************
  // delayed one-cycle high-byte read
  // ***********************************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wait_r <= 5'h00;
    end else if (fetch) begin
      wait_r <= {1'b0, gap} + 5'h01;
    end else if (wait_r != 5'h00) begin
      wait_r <= wait_r - 5'h01;
    end
  end
  assign high_byte_rd = (wait_r == 5'h01); // ends the frozen window
endmodule

// ===== verification/test_fan_monitor_alert_config_regs.sv
// Purpose: self-checking bench for the alert and configuration registers
// Assumes: registers reached by single-cycle reg_wr and reg_rd pulses
// Notes: short step and tach counts keep the run brief
`timescale 1ns/10ps
module test_fan_monitor_alert_config_regs;
  logic clk_sys, resetn, reg_wr, reg_rd, lock, dir_out, pin_n, fetch, hb;
  logic tev, f2a, oen, ffull, tick, aln;
  logic [7:0] addr, wdata, rdata, tlim, st1, st2, rv, m1, m2, c3;
  logic [1:0] pfun;
  logic [3:0] ctach, sten;
  logic [9:0] ms [5];
  logic [9:0] old [5];
  logic [7:0] hi [5];
  logic [31:0] seed = 32'h51;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  fmac_regs #(.STEP_CYC(20), .SLOW_CYC(40), .FAST_CYC(10)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(wdata), .reg_rdata(rdata), .lock(lock),
    .shared_pin_function(pfun), .overheat_pin_dir_out(dir_out),
    .timer_limit(tlim), .status_one(st1), .status_two(st2),
    .supply_one_meas(ms[0]), .supply_two_meas(ms[1]),
    .remote_one_meas(ms[2]), .local_meas(ms[3]), .remote_two_meas(ms[4]),
    .high_byte_rd(hb), .overheat_pin_n(pin_n), .supply_one_high(hi[0]),
    .supply_two_high(hi[1]), .remote_one_high(hi[2]), .local_high(hi[3]),
    .remote_two_high(hi[4]), .timer_event(tev), .fan_two_is_alert(f2a),
    .alert_n(aln), .overheat_enable(oen), .fans_full(ffull),
    .tach_tick(tick), .continuous_tach(ctach), .stretch_enable(sten));
  fmac_host_model host (.clk_sys(clk_sys), .resetn(resetn), .fetch(fetch),
    .gap(4'h3), .high_byte_rd(hb));
  // ***********************************************************************
  // helpers
  // ***********************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic exp_aln(logic [7:0] s1, s2, a, b);
    return !(|(s1 & 8'h76 & ~a) | (!a[7] & |(s2 & 8'hFE & ~{b[7:2], 2'h0})));
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys) {addr, wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk_sys) reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk_sys) {addr, reg_rd} = {a, 1'b1};
    #1 rv = rdata;
    @(negedge clk_sys) reg_rd = 1'b0;
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ***********************************************************************
  // clock, watchdog and stimulus
  // ***********************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    {resetn, reg_wr, reg_rd, lock, dir_out, fetch} = 6'h00;
    {addr, wdata, tlim, st1, st2} = '0;
    {pin_n, pfun} = 3'h4;
    for (int i = 0; i < 5; i++) ms[i] = 10'h000;
    cyc(20);
    resetn = 1'b1;
    for (int a = 8'h74; a <= 8'h7A; a++) begin
      rd(a[7:0]);
      chk(rv, 8'h00); // power-on values and unmapped read
    end
    @(negedge clk_sys) fetch = 1'b1; // end the freeze left by the reads
    @(negedge clk_sys) fetch = 1'b0;
    cyc(6);
    $display("test reset values done");
    wr(8'h78, 8'h01);
    for (int i = 0; i < 16; i++) begin
      m1 = (i == 0) ? 8'h80 : rnd();
      m2 = rnd();
      wr(8'h74, m1);
      wr(8'h75, m2);
      @(negedge clk_sys) {st1, st2} = {rnd() & 8'h76, rnd() & 8'hFE};
      #1 chk(aln, exp_aln(st1, st2, m1, m2));
      rd(8'h74);
      chk(rv, m1);
      rd(8'h75);
      chk(rv, m2 & 8'hFC);
    end
    {st1, st2} = 16'h0000;
    $display("test alert masks done");
    for (int i = 0; i < 8; i++) begin
      c3 = rnd();
      pfun = i[1:0];
      wr(8'h78, c3);
      rd(8'h78);
      chk(rv, c3);
      chk(f2a, c3[0]);
      chk(oen, c3[1] && pfun != 2'h0);
      chk(ctach, c3[7:4]);
      chk(sten, {4'h0, ~c3[7:4]});
      lock = 1'b1;
      wr(8'h78, ~c3);
      rd(8'h78);
      chk(rv, c3);
      lock = 1'b0;
    end
    $display("test config three done");
    for (int f = 0; f < 2; f++) begin
      wr(8'h78, f ? 8'h08 : 8'h00);
      n = 0;
      while (tick !== 1'b1 && n < 100) begin
        cyc(1);
        n++;
      end
      n = 0;
      cyc(1);
      while (tick !== 1'b1 && n < 100) begin
        cyc(1);
        n++;
      end
      chk(n + 1, f ? 10 : 40);
    end
    $display("test tach rate done");
    for (int i = 0; i < 5; i++) old[i] = rnd();
    ms = old;
    rd(8'h76);
    chk(rv, {2'h0, old[1][1:0], old[0][1:0], 2'h0});
    for (int i = 0; i < 5; i++) ms[i] = ~old[i];
    rd(8'h77);
    chk(rv, {old[4][1:0], old[3][1:0], old[2][1:0], 2'h0});
    for (int i = 0; i < 5; i++) chk(hi[i], old[i][9:2]);
    @(negedge clk_sys) fetch = 1'b1;
    @(negedge clk_sys) fetch = 1'b0;
    cyc(6);
    for (int i = 0; i < 5; i++) chk(hi[i], ~old[i][9:2]);
    $display("test frozen low bits done");
    {pfun, tlim, m2} = {2'h1, 8'h02, 8'h00};
    wr(8'h74, 8'h00);
    wr(8'h75, 8'h00);
    wr(8'h78, 8'h07);
    @(negedge clk_sys) pin_n = 1'b0;
    cyc(3);
    chk(ffull, 1'b1);
    rd(8'h79);
    chk(rv, 8'h01);
    rd(8'h79);
    chk(rv, 8'h00);
    cyc(100);
    rd(8'h79);
    chk(rv[7:1] > 7'h01, 1'b1);
    chk(tev, 1'b1);
    chk(aln, 1'b0);
    wr(8'h75, 8'h20);
    chk(aln, 1'b1);
    @(negedge clk_sys) {pin_n, tlim, fetch} = {1'b1, 8'h00, 1'b1};
    @(negedge clk_sys) fetch = 1'b0;
    cyc(6);
    chk(ffull, 1'b0);
    chk(tev, 1'b0);
    @(negedge clk_sys) pin_n = 1'b0;
    cyc(3);
    chk(tev, 1'b1);
    @(negedge clk_sys) dir_out = 1'b1;
    #1 chk(ffull, 1'b0);
    dir_out = 1'b0;
    $display("test overheat timer done");
    stop_test();
  end
endmodule
